// [hw/banked_data_memory_mapper.sv]
// data memory address mapper: bank pointer, access map and memory targets
`timescale 1ns/1ns
`default_nettype none
module banked_data_memory_mapper #(
    parameter int QUARTER_DIV = 1
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // execute stage request, sampled at q1
    input  wire logic                   instr_valid,
    input  wire data_map_pkg::op_kind_t instr_kind,
    input  wire logic                   access_sel,
    input  wire logic [7:0]             operand,
    input  wire logic [11:0]            src_addr,
    input  wire logic [11:0]            dst_addr,
    input  wire logic                   dest_wr,
    // execute stage write data, sampled at q4
    input  wire logic [7:0]             wr_data,
    // execute stage answers
    output logic [7:0]                  rd_data_q,
    output logic                        rd_valid_q,
    output logic                        flags_update_q,
    output logic                        busy_q,
    output logic [3:0]                  bank_pointer_q,
    output logic [3:0]                  quarter_q,
    // special function register slave side
    output logic [7:0]                  sfr_addr_q,
    output logic                        sfr_rd_q,
    output logic                        sfr_wr_q,
    output logic [7:0]                  sfr_wdata_q,
    input  wire logic [7:0]             sfr_rdata,
    // usb protocol engine port on the buffer bank
    input  wire logic                   usb_enable,
    input  wire logic                   usb_req,
    input  wire logic                   usb_we,
    input  wire logic [7:0]             usb_addr,
    input  wire logic [7:0]             usb_wdata,
    output logic [7:0]                  usb_rdata_q
);
    import data_map_pkg::*;

    initial begin
        if (QUARTER_DIV < 1) $error("mapper: QUARTER_DIV must be at least 1");
        if (ADDR_W != BANK_W + OFS_W) $error("mapper: address split inconsistent");
    end

    // quarter enables
    logic [3:0] q_en;

    quarter_phase_gen #(
        .DIV     (QUARTER_DIV)
    ) u_phase (
        .clk     (clk),
        .sys_rst (sys_rst),
        .q_en    (q_en)
    );

    wire q1 = q_en[0];
    wire q2 = q_en[1];
    wire q3 = q_en[2];
    wire q4 = q_en[3];

    // sequencer state and captured instruction
    seq_state_t  state_q;
    seq_state_t  state_d;
    op_kind_t    kind_q;
    logic        wr_req_q;
    logic [11:0] rd_addr_q;
    logic [11:0] wr_addr_q;
    target_t     rd_tgt_q;
    logic [3:0]  bp_q;

    // address formation from the instruction fields
    wire        access_hi   = (operand >= ACCESS_SPLIT);
    wire [3:0]  access_bank = access_hi ? ACCESS_HI_BANK : ACCESS_LO_BANK;
    // access map ignores the pointer entirely
    wire [3:0]  sel_bank    = access_sel ? bp_q : access_bank;
    wire [11:0] file_addr   = {sel_bank, operand};
    // full move uses its own addresses, never the pointer
    wire [11:0] next_rd     = (instr_kind == OP_FULL) ? src_addr : file_addr;
    wire [11:0] next_wr     = (instr_kind == OP_FULL) ? dst_addr : file_addr;
    wire        next_wr_req = (instr_kind == OP_FULL) |
                              ((instr_kind == OP_FILE) & dest_wr);

    // decode of a 12-bit address into its target
    function automatic target_t decode(input logic [11:0] a);
        logic [3:0] bank;
        logic [7:0] ofs;
        bank = a[11:8];
        ofs  = a[7:0];
        decode = TGT_NONE;
        if (a == BANK_POINTER_ADDR) begin
            decode = TGT_BP;
        end else if (bank == GPR_BANK) begin
            decode = TGT_GPR;
        end else if (bank == BUFFER_BANK) begin
            decode = TGT_BUF;
        end else if (bank == SFR_BANK && ofs >= SFR_LOW_OFS) begin
            // f53h-f5fh exist here but the access map never lands below f60h
            decode = TGT_SFR;
        end
    endfunction : decode

    wire target_t rd_tgt = decode(rd_addr_q);
    wire target_t wr_tgt = decode(wr_addr_q);

    // full move writes back what it read; file ops write the alu result
    wire [7:0] wr_value = (kind_q == OP_FULL) ? rd_data_q : wr_data;

    // strobes, all at the documented quarters
    wire do_rd     = (state_q == ST_READ) & q2 & (kind_q != OP_LOADB);
    wire do_wr     = (state_q == ST_WRITE) & q4 & wr_req_q;
    wire gpr_wr    = do_wr & (wr_tgt == TGT_GPR);
    wire buf_wr    = do_wr & (wr_tgt == TGT_BUF);
    wire bp_wr     = do_wr & (wr_tgt == TGT_BP);
    wire sfr_wr    = do_wr & (wr_tgt == TGT_SFR);
    wire buf_rd    = do_rd & (rd_tgt == TGT_BUF);
    wire sfr_rd    = do_rd & (rd_tgt == TGT_SFR);
    wire loadb_go  = (state_q == ST_WRITE) & q4 & (kind_q == OP_LOADB);
    wire seq_done  = (state_q == ST_WRITE) & q4;
    wire [7:0] buf_addr = do_wr ? wr_addr_q[7:0] : rd_addr_q[7:0];

    // next state: one instruction per four quarters
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (q1 && instr_valid && instr_kind != OP_NONE) state_d = ST_READ;
            ST_READ:  if (q2) state_d = ST_FETCH;
            ST_FETCH: if (q3) state_d = ST_WRITE;
            ST_WRITE: if (q4) state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // sequencer register
    always_ff @(posedge clk) begin
        if (sys_rst) state_q <= ST_IDLE;
        else state_q <= state_d;
    end

    // capture the instruction at q1
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kind_q    <= OP_NONE;
            wr_req_q  <= 1'b0;
            rd_addr_q <= 12'h000;
            wr_addr_q <= 12'h000;
        end else if (state_q == ST_IDLE && q1 && instr_valid) begin
            kind_q    <= instr_kind;
            wr_req_q  <= next_wr_req;
            rd_addr_q <= next_rd;
            wr_addr_q <= next_wr;
        end
    end

    // bank pointer: only four bits exist, upper bits are not stored at all
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bp_q <= BANK_POINTER_RESET;
        end else if (loadb_go) begin
            // literal from the q1 capture; the live operand may have moved on by q4
            bp_q <= rd_addr_q[BANK_POINTER_IMPL-1:0];
        end else if (bp_wr) begin
            bp_q <= wr_value[BANK_POINTER_IMPL-1:0];
        end
    end

    // bank 0 general memory; contents kept through every reset
    logic [7:0] gpr_mem [0:BANK_SIZE-1];
    logic [7:0] gpr_rd_q;

    always_ff @(posedge clk) begin
        if (gpr_wr) gpr_mem[wr_addr_q[7:0]] <= wr_value;
    end

    // registered operand read of bank 0
    always_ff @(posedge clk) begin
        if (do_rd && rd_tgt == TGT_GPR) gpr_rd_q <= gpr_mem[rd_addr_q[7:0]];
    end

    // buffer bank, shared with the usb engine when it is enabled
    logic [7:0] buf_rd_data;

    dual_access_buffer #(
        .DEPTH      (BANK_SIZE)
    ) u_buffer (
        .clk        (clk),
        .core_rd    (buf_rd),
        .core_wr    (buf_wr),
        .core_addr  (buf_addr),
        .core_wdata (wr_value),
        .core_rdata (buf_rd_data),
        .usb_enable (usb_enable),
        .usb_req    (usb_req),
        .usb_we     (usb_we),
        .usb_addr   (usb_addr),
        .usb_wdata  (usb_wdata),
        .usb_rdata  (usb_rdata_q)
    );

    // target of the read in flight, for the q3 data select
    always_ff @(posedge clk) begin
        if (sys_rst) rd_tgt_q <= TGT_NONE;
        else if (do_rd) rd_tgt_q <= rd_tgt;
    end

    // special register slave strobes; one clock wide each
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rd_q    <= 1'b0;
            sfr_wr_q    <= 1'b0;
            sfr_addr_q  <= 8'h00;
            sfr_wdata_q <= 8'h00;
        end else begin
            sfr_rd_q <= sfr_rd;
            sfr_wr_q <= sfr_wr;
            if (sfr_rd) sfr_addr_q <= rd_addr_q[7:0];
            if (sfr_wr) begin
                sfr_addr_q  <= wr_addr_q[7:0];
                sfr_wdata_q <= wr_value;
            end
        end
    end

    // read data select; unimplemented places give zero
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (rd_tgt_q)
            TGT_GPR:  rd_mux = gpr_rd_q;
            TGT_BUF:  rd_mux = buf_rd_data;
            TGT_BP:   rd_mux = {4'h0, bp_q};
            TGT_SFR:  rd_mux = sfr_rdata;
            TGT_NONE: rd_mux = 8'h00;
            default:  rd_mux = 8'h00;
        endcase
    end

    // operand returned to the execute stage at q3
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= (state_q == ST_FETCH) & q3 & (kind_q != OP_LOADB);
            if ((state_q == ST_FETCH) && q3) begin
                rd_data_q <= (kind_q == OP_LOADB) ? 8'h00 : rd_mux;
            end
        end
    end

    // flags follow every file operation, hit or miss alike
    always_ff @(posedge clk) begin
        if (sys_rst) flags_update_q <= 1'b0;
        else flags_update_q <= seq_done & (kind_q == OP_FILE);
    end

    // status outputs for the execute stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q         <= 1'b0;
            bank_pointer_q <= BANK_POINTER_RESET;
            quarter_q      <= 4'h0;
        end else begin
            busy_q         <= (state_d != ST_IDLE);
            bank_pointer_q <= bp_q;
            quarter_q      <= q_en;
        end
    end

    // extended instruction set remapping is not modelled here

endmodule : banked_data_memory_mapper
`default_nettype wire

// [hw/data_map_pkg.sv]
// constants and types shared by the data memory address mapper
// Behaviour
// - data memory uses a 12-bit byte address, 4096 bytes in all
// - sixteen banks of 256 bytes; upper 4 bits bank, lower 8 bits offset
// - reading any unimplemented location returns zero
// - with usb off, the buffer bank behaves as plain general memory
// - with usb on, core and usb engine both reach the buffer bank
// - banked access: bank pointer gives top 4 bits, operand gives low 8
// - only bank pointer bits 3..0 exist; upper bits read zero, ignore writes
// - load-bank-literal instruction loads the bank pointer from an immediate
// - any bank selectable; unimplemented bank drops writes, reads zero
// - flags update as usual even when the target bank is unimplemented
// - full-address move carries both 12-bit addresses, ignores bank pointer
// - other instructions complete the operand via bank pointer or access map
// - access map: 00h-5Fh to bank 0 start, 60h-FFh to bank 15 top
// - both access regions form one linear space indexed by the operand
// - access-select bit 1 uses bank pointer plus operand
// - access-select bit 0 uses access map and ignores the bank pointer
// - access-map accesses finish in one instruction cycle, no pointer update
// - registers F53h-F5Fh reachable only banked or by full-address move
// - bank 2, 200h-2FFh, holds the dual-access buffer ram
// - operand read in the second quarter, destination written in the fourth
// - general memory is never cleared by any reset
package data_map_pkg;

    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFS_W  = 8;
    localparam int DATA_W = 8;
    localparam int BANK_SIZE = 256;

    // bank numbers of the smaller memory variant
    localparam logic [3:0] GPR_BANK    = 4'h0;
    localparam logic [3:0] BUFFER_BANK = 4'h2;
    localparam logic [3:0] SFR_BANK    = 4'hf;

    // access map split and special register window
    localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [7:0] SFR_LOW_OFS    = 8'h53;

    // bank pointer location and layout
    localparam logic [11:0] BANK_POINTER_ADDR  = 12'hfe0;
    localparam int          BANK_POINTER_IMPL  = 4;
    localparam logic [3:0]  BANK_POINTER_RESET = 4'h0;

    // quarter phases, one-hot
    localparam logic [3:0] PHASE_Q1 = 4'h1;

    // instruction kinds presented by the execute stage
    typedef enum logic [1:0] {
        OP_FILE  = 2'h0,
        OP_FULL  = 2'h1,
        OP_LOADB = 2'h2,
        OP_NONE  = 2'h3
    } op_kind_t;

    // target classes after decode
    typedef enum logic [2:0] {
        TGT_NONE = 3'h0,
        TGT_GPR  = 3'h1,
        TGT_BUF  = 3'h2,
        TGT_BP   = 3'h3,
        TGT_SFR  = 3'h4
    } target_t;

    // instruction cycle sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_WRITE = 4'b1000
    } seq_state_t;

endpackage : data_map_pkg

// [hw/quarter_phase_gen.sv]
// quarter-cycle enable pulse generator
`timescale 1ns/1ns
`default_nettype none
module quarter_phase_gen #(
    parameter int DIV = 1
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // one-cycle enables q1..q4 in bits 0..3
    output logic [3:0]      q_en
);
    import data_map_pkg::*;

    initial begin
        if (DIV < 1) $error("quarter_phase_gen: DIV must be at least 1");
    end

    localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CNT_W-1:0] cnt_q;
    logic [3:0]       phase_q;
    wire              tick = (cnt_q == CNT_W'(DIV - 1));

    // divider and rotating phase; q1 first after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q   <= '0;
            phase_q <= PHASE_Q1;
        end else if (tick) begin
            cnt_q   <= '0;
            phase_q <= {phase_q[2:0], phase_q[3]};
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    assign q_en = phase_q & {4{tick}};

endmodule : quarter_phase_gen
`default_nettype wire

// [hw/dual_access_buffer.sv]
// dual-access buffer ram shared by core and usb engine
`timescale 1ns/1ns
`default_nettype none
module dual_access_buffer #(
    parameter int DEPTH = 256
) (
    // clock
    input  wire logic                clk,
    // core port
    input  wire logic                core_rd,
    input  wire logic                core_wr,
    input  wire logic [7:0]          core_addr,
    input  wire logic [7:0]          core_wdata,
    output logic [7:0]               core_rdata,
    // usb engine port
    input  wire logic                usb_enable,
    input  wire logic                usb_req,
    input  wire logic                usb_we,
    input  wire logic [7:0]          usb_addr,
    input  wire logic [7:0]          usb_wdata,
    output logic [7:0]               usb_rdata
);
    import data_map_pkg::*;

    initial begin
        if (DEPTH != BANK_SIZE) $error("dual_access_buffer: DEPTH must equal one bank");
    end

    // no reset on contents: memory survives every reset
    logic [7:0] mem [0:DEPTH-1];

    wire usb_go = usb_enable & usb_req;

    // core write is placed last so it wins a same-address collision
    always_ff @(posedge clk) begin
        if (usb_go && usb_we) mem[usb_addr] <= usb_wdata;
        if (core_wr) mem[core_addr] <= core_wdata;
    end

    // registered read on each port
    always_ff @(posedge clk) begin
        if (core_rd) core_rdata <= mem[core_addr];
        if (usb_go && !usb_we) usb_rdata <= mem[usb_addr];
    end

endmodule : dual_access_buffer
`default_nettype wire

// [sim/banked_data_memory_mapper_asserts.sv]
// concurrent checks on the ports of the data memory address mapper
`timescale 1ns/1ns
`default_nettype none
module banked_data_memory_mapper_asserts
    import data_map_pkg::*;
#(
    parameter int QUARTER_DIV = 1
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // execute stage request
    input  wire data_map_pkg::op_kind_t instr_kind,
    input  wire logic                   access_sel,
    input  wire logic [7:0]             operand,
    input  wire logic [11:0]            src_addr,
    // answers
    input  wire logic                   rd_valid_q,
    input  wire logic                   flags_update_q,
    input  wire logic                   busy_q,
    input  wire logic [3:0]             bank_pointer_q,
    input  wire logic [3:0]             quarter_q,
    // special register side
    input  wire logic [7:0]             sfr_addr_q,
    input  wire logic                   sfr_rd_q,
    input  wire logic                   sfr_wr_q
);
    // figures assume one clock per quarter; the take edge is one before busy rises
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_flags_pulse;
        $rose(busy_q) && $past(instr_kind) == OP_FILE |-> ##2 !flags_update_q ##1 flags_update_q;
    endproperty
    a_flags_pulse: assert property (p_flags_pulse) else $error("flags pulse off its slot");

    property p_read_slot;
        $rose(busy_q) && $past(instr_kind) != OP_LOADB |-> ##1 !rd_valid_q ##1 rd_valid_q;
    endproperty
    a_read_slot: assert property (p_read_slot) else $error("operand not read in slot");

    property p_sfr_pulse;
        sfr_rd_q |=> !sfr_rd_q;
    endproperty
    a_sfr_pulse: assert property (p_sfr_pulse) else $error("register read strobe too long");

    property p_sfr_window;
        sfr_rd_q || sfr_wr_q |-> sfr_addr_q >= 8'h53 && sfr_addr_q != 8'he0;
    endproperty
    a_sfr_window: assert property (p_sfr_window) else $error("register strobe off window");

    property p_access_low;
        $rose(busy_q) && $past(instr_kind) == OP_FILE && !$past(access_sel)
            && $past(operand) < 8'h60 |-> (!sfr_rd_q && !sfr_wr_q) [*4];
    endproperty
    a_access_low: assert property (p_access_low) else $error("low access hit registers");

    property p_access_high;
        $rose(busy_q) && $past(instr_kind) == OP_FILE && !$past(access_sel)
            && $past(operand) >= 8'h60 && $past(operand) != 8'he0
            |-> ##1 sfr_rd_q && sfr_addr_q == $past(operand, 2);
    endproperty
    a_access_high: assert property (p_access_high) else $error("high access missed register");

    property p_full_src;
        $rose(busy_q) && $past(instr_kind) == OP_FULL && $past(src_addr) >= 12'hf53
            && $past(src_addr) != 12'hfe0 |-> ##1 sfr_rd_q && {4'hf, sfr_addr_q} == $past(src_addr, 2);
    endproperty
    a_full_src: assert property (p_full_src) else $error("full move source wrong");

    property p_load_bank;
        $rose(busy_q) && $past(instr_kind) == OP_LOADB
            |-> ##4 {4'h0, bank_pointer_q} == ($past(operand, 5) & 8'h0f);
    endproperty
    a_load_bank: assert property (p_load_bank) else $error("bank pointer load wrong");

    property p_reset_state;
        $fell(sys_rst) |-> bank_pointer_q == 4'h0 && !busy_q && !rd_valid_q;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");

    property p_quarter_onehot;
        !$past(sys_rst) && !$past(sys_rst, 2) |-> $onehot(quarter_q);
    endproperty
    a_quarter_onehot: assert property (p_quarter_onehot) else $error("quarter phase not one-hot");
endmodule : banked_data_memory_mapper_asserts

bind banked_data_memory_mapper banked_data_memory_mapper_asserts #(
    .QUARTER_DIV(QUARTER_DIV)
) u_asserts (.clk, .sys_rst, .instr_kind, .access_sel, .operand, .src_addr, .rd_valid_q,
    .flags_update_q, .busy_q, .bank_pointer_q, .quarter_q, .sfr_addr_q, .sfr_rd_q, .sfr_wr_q);
`default_nettype wire

// [sim/sfr_slave_model.sv]
// behavioural special function register slave facing the mapper
`timescale 1ns/1ns
`default_nettype none
module sfr_slave_model (
    // clock
    input  wire logic       clk,
    // strobes from the mapper
    input  wire logic [7:0] sfr_addr_q,
    input  wire logic       sfr_rd_q,
    input  wire logic       sfr_wr_q,
    input  wire logic [7:0] sfr_wdata_q,
    output logic [7:0]      sfr_rdata
);
    logic [7:0] regs_q [256];
    logic [7:0] last_q;

    // start at zero so the bench can predict every register
    initial begin
        foreach (regs_q[i]) regs_q[i] = 8'h00;
        last_q = 8'h00;
    end

    // store on the write pulse, remember what was last shown
    always @(posedge clk) begin
        if (sfr_wr_q) regs_q[sfr_addr_q] <= sfr_wdata_q;
        if (sfr_rd_q) last_q <= regs_q[sfr_addr_q];
    end

    // valid only under the read pulse; inverted junk otherwise, no free stale data
    assign sfr_rdata = sfr_rd_q ? regs_q[sfr_addr_q] : ~last_q;
endmodule : sfr_slave_model
`default_nettype wire

// [sim/banked_data_memory_mapper_test.sv]
// self-checking bench for the data memory address mapper
`timescale 1ns/1ns
`default_nettype none
module banked_data_memory_mapper_test;
    import data_map_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, access_sel = 1'b0;
    logic        dest_wr = 1'b0, usb_enable = 1'b0, usb_req = 1'b0, usb_we = 1'b0;
    op_kind_t    instr_kind = OP_NONE;
    logic [7:0]  operand = 8'h00, wr_data = 8'h00, usb_addr = 8'h00, usb_wdata = 8'h00;
    logic [11:0] src_addr = 12'h000, dst_addr = 12'h000, x;
    logic [7:0]  rd_data_q, sfr_addr_q, sfr_wdata_q, sfr_rdata, usb_rdata_q, rd, q;
    logic        rd_valid_q, flags_update_q, busy_q, sfr_rd_q, sfr_wr_q, fl;
    logic [3:0]  bank_pointer_q, quarter_q, exp_bp;
    logic [7:0]  exp_mem [4096];
    int          fails = 0, compares = 0;

    banked_data_memory_mapper #(.QUARTER_DIV(1)) dut (.clk, .sys_rst, .instr_valid, .instr_kind,
        .access_sel, .operand, .src_addr, .dst_addr, .dest_wr, .wr_data, .rd_data_q, .rd_valid_q,
        .flags_update_q, .busy_q, .bank_pointer_q, .quarter_q, .sfr_addr_q, .sfr_rd_q, .sfr_wr_q,
        .sfr_wdata_q, .sfr_rdata, .usb_enable, .usb_req, .usb_we, .usb_addr, .usb_wdata,
        .usb_rdata_q);
    sfr_slave_model partner (.clk, .sfr_addr_q, .sfr_rd_q, .sfr_wr_q, .sfr_wdata_q, .sfr_rdata);

    always #2 clk = ~clk;

    // expected address, presence and contents of a location
    function automatic logic [11:0] eff(input logic a, input logic [7:0] o, input logic [3:0] b);
        return a ? {b, o} : (o < ACCESS_SPLIT ? {4'h0, o} : {4'hf, o});
    endfunction : eff
    function automatic logic impl(input logic [11:0] a);
        return a[11:8] == 4'h0 || a[11:8] == BUFFER_BANK || a >= 12'hf53;
    endfunction : impl
    function automatic logic [7:0] exp_rd(input logic [11:0] a);
        if (a == BANK_POINTER_ADDR) return {4'h0, exp_bp};
        return impl(a) ? exp_mem[a] : 8'h00;
    endfunction : exp_rd
    task automatic put(input logic [11:0] a, input logic [7:0] v);
        if (impl(a)) exp_mem[a] = v;
    endtask : put

    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check_byte
    task automatic check_flag(input logic s);
        compares++;
        if (s !== 1'b1) begin
            fails++;
            $display("wrong value flags_update_q expected 1 seen %b", s);
        end
    endtask : check_flag

    // hold the request until busy shows it taken, then collect the answers
    task automatic run_op(input op_kind_t k, input logic a, input logic [7:0] o,
                          input logic [11:0] s, input logic [11:0] d, input logic w,
                          input logic [7:0] wd);
        int n;
        n = 0;
        rd = 8'hxx;
        fl = 1'b0;
        @(negedge clk);
        instr_valid = 1'b1;
        instr_kind = k;
        access_sel = a;
        operand = o;
        src_addr = s;
        dst_addr = d;
        dest_wr = w;
        wr_data = wd;
        while (busy_q !== 1'b1 && n < 12) @(negedge clk) n++;
        if (busy_q !== 1'b1) fails++;
        instr_valid = 1'b0;
        do @(negedge clk) begin
            if (rd_valid_q === 1'b1) rd = rd_data_q;
            if (flags_update_q === 1'b1) fl = 1'b1;
            n++;
        end while (busy_q === 1'b1 && n < 24);
        if (n >= 24) fails++;
    endtask : run_op
    task automatic load_bank(input logic [7:0] v);
        run_op(OP_LOADB, 1'b0, v, 12'h000, 12'h000, 1'b0, 8'h00);
        exp_bp = v[3:0];
    endtask : load_bank
    task automatic file_wr(input logic a, input logic [7:0] o, input logic [7:0] v);
        run_op(OP_FILE, a, o, 12'h000, 12'h000, 1'b1, v);
        check_flag(fl);
        put(eff(a, o, exp_bp), v);
    endtask : file_wr
    task automatic file_rd(input logic a, input logic [7:0] o);
        run_op(OP_FILE, a, o, 12'h000, 12'h000, 1'b0, 8'h00);
        check_byte("rd_data_q", exp_rd(eff(a, o, exp_bp)), rd);
        check_flag(fl);
    endtask : file_rd
    task automatic full_mv(input logic [11:0] s, input logic [11:0] d);
        run_op(OP_FULL, 1'b0, 8'h00, s, d, 1'b0, 8'h00);
        check_byte("moved byte", exp_rd(s), rd);
        put(d, exp_rd(s));
    endtask : full_mv
    // one-cycle request from the usb side, then scrambled lines
    task automatic usb_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        usb_req = 1'b1;
        usb_we = w;
        usb_addr = a;
        usb_wdata = d;
        @(negedge clk);
        usb_req = 1'b0;
        usb_addr = ~a;
        usb_wdata = ~d;
        @(negedge clk);
        q = usb_rdata_q;
    endtask : usb_op

    task automatic tally_and_finish;
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // watchdog well past the expected run length
    initial begin
        #80000;
        fails++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(34410));
        exp_bp = 4'h0;
        for (int i = 12'hf53; i < 4096; i++) exp_mem[i] = 8'h00;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        // corners: pointer width, map versus pointer, window edge, buffer use
        load_bank(8'ha7);
        file_rd(1'b0, 8'he0);
        file_wr(1'b0, 8'h10, 8'h5a);
        file_rd(1'b1, 8'h10);
        load_bank(8'h00);
        file_rd(1'b1, 8'h10);
        file_wr(1'b0, 8'h53, 8'h3c);
        full_mv(12'h053, 12'h200);
        full_mv(12'h200, 12'h001);
        usb_enable = 1'b1;
        usb_op(1'b1, 8'h40, 8'h96);
        put(12'h240, 8'h96);
        load_bank(8'h02);
        file_rd(1'b1, 8'h40);
        file_wr(1'b1, 8'h41, 8'he1);
        usb_op(1'b0, 8'h41, 8'h00);
        check_byte("usb_rdata_q", 8'he1, q);
        usb_enable = 1'b0;
        usb_op(1'b1, 8'h41, 8'h00);
        file_rd(1'b1, 8'h41);
        // memory survives a reset, pointer does not
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        exp_bp = 4'h0;
        file_rd(1'b0, 8'h10);
        // access map high half lands on registers; low window never reaches f53h-f5fh
        file_wr(1'b0, 8'h61, 8'h7e);
        file_rd(1'b0, 8'h61);
        file_wr(1'b0, 8'h55, 8'h11);
        load_bank(8'h0f);
        file_wr(1'b1, 8'h55, 8'ha5);
        file_rd(1'b0, 8'h55);
        full_mv(12'hf55, 12'h002);
        // random banked writes read back by full move and access map
        repeat (40) begin
            x = 12'($urandom());
            if (x[1:0] == 2'h0) x[11:8] = 4'h0;
            if (x[1:0] == 2'h1) x[11:8] = BUFFER_BANK;
            if (x == BANK_POINTER_ADDR) x = 12'hfe1;
            load_bank({4'($urandom()), x[11:8]});
            file_wr(1'b1, x[7:0], 8'($urandom()));
            full_mv(x, 12'h05f);
            file_rd(1'b0, 8'h5f);
        end
        tally_and_finish();
    end
endmodule : banked_data_memory_mapper_test
`default_nettype wire
